// File: src/d2d_slice_pkg.sv
package d2d_slice_pkg;

  // Register byte offsets on the programming bus.
  localparam logic [11:0] CTRL_OFFS     = 12'h000;
  localparam logic [11:0] STATUS_OFFS   = 12'h004;
  localparam logic [11:0] TX_WORDS_OFFS = 12'h008;
  localparam logic [11:0] RX_WORDS_OFFS = 12'h00c;
  localparam logic [11:0] CONFIG_OFFS   = 12'h010;

  // Control register fields.
  localparam int CTRL_TX_EN_BIT = 0;
  localparam int CTRL_RX_EN_BIT = 1;
  localparam int CTRL_LOOP_BIT  = 2;
  localparam int CTRL_WIDTH     = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // Status register fields.
  localparam int STAT_TX_RUN_BIT   = 0;
  localparam int STAT_RX_RUN_BIT   = 1;
  localparam int STAT_RX_WAIT_BIT  = 2;
  localparam int STAT_CONFLICT_BIT = 3;
  localparam int STAT_LOOP_BIT     = 4;

  // Configuration register fields, read only.
  localparam int CFG_RATIO_POS  = 0;
  localparam int CFG_EXTRA_BIT  = 16;

  // Word counters restart from zero.
  localparam logic [31:0] COUNT_RESET = 32'h0000_0000;

  // Number of single-ended lane wires in one slice.
  localparam int LANES = 16;

  // Transmit path states.
  typedef enum logic [0:0] {
    TX_OFF,
    TX_RUN
  } tx_state_t;

  // Receive path states.
  typedef enum logic [1:0] {
    RX_OFF,
    RX_WAIT_CLK,
    RX_RUN
  } rx_state_t;

endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin inputs.
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  // The first stage feeds only the second one, to keep metastability contained.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = din;
    st_nxt.s2 = st_r.s1;
  end

  // Synchronous reset clears both stages.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.s2;

endmodule

// File: src/d2d_phy_slice_gearbox.sv
// Overview of operation
// R01 - Slice has one forwarded differential clock pair and 16 lane wires, extras optional.
// R02 - Error-correction coding is the link layer's job; slice just moves that bit.
// R03 - Extra wire never changes rates; logic clock stays fast clock over power of two.
// R04 - Error and side wires both present or both absent, carried untouched.
// R05 - Bus inversion coding on the side wire lives in both link layers.
// R06 - Parallel data changes once per logic clock cycle, single data rate.
// R07 - Parallel word is 16*N bits; error and side fields N bits or absent.
// R08 - Transmit fast clock comes from a clock source, not the link layer.
// R09 - Transmit slice outputs a logic clock that paces the send word.
// R10 - Receive slice outputs word, extras, logic clock, and optional recovered clock.
// R11 - A slice only sends or only receives; it may be configurable either way.
// R12 - One shared wire set, separate send and receive groups toward core.
// R13 - Only one path enabled in mission mode; both only in loopback.
// R14 - Loopback should be enabled on one slice at a time.
// R15 - Wires run double data rate: one bit per forwarded clock edge.
// R16 - Logic clock is the fast clock divided by a power of two.
// R17 - Lane i carries bits i, i+16, ...; lowest group goes first.
// R18 - Receiver derives its logic clock from the forwarded clock, word-aligned.
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module d2d_phy_slice_gearbox
  import d2d_slice_pkg::*;
#(
  parameter int RATIO     = 4,
  parameter bit HAS_EXTRA = 1'b1
) (
  input  wire logic                     sys_clk,
  input  wire logic                     nrst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic [16*RATIO-1:0]      send_parallel_word,
  input  wire logic [RATIO-1:0]         send_err_corr_bits,
  input  wire logic [RATIO-1:0]         send_side_bits,
  output logic                          send_logic_clock,
  output logic [16*RATIO-1:0]           recv_parallel_word,
  output logic [RATIO-1:0]              recv_err_corr_bits,
  output logic [RATIO-1:0]              recv_side_bits,
  output logic                          recv_logic_clock,
  output logic                          recv_fast_clk_out,
  input  wire logic [15:0]              lane_wires_in,
  output logic      [15:0]              lane_wires_out,
  output logic      [15:0]              lane_wires_oe,
  input  wire logic                     err_corr_wire_in,
  output logic                          err_corr_wire_out,
  output logic                          err_corr_wire_oe,
  input  wire logic                     side_wire_in,
  output logic                          side_wire_out,
  output logic                          side_wire_oe,
  input  wire logic                     fwd_clk_in,
  output logic                          fwd_clk_p_out,
  output logic                          fwd_clk_n_out,
  output logic                          fwd_clk_oe
);

  // R07 word width
  localparam int WORD = LANES * RATIO;
  localparam int CW   = (RATIO > 2) ? $clog2(RATIO) : 1;
  localparam logic [CW-1:0] LAST_BEAT = CW'(RATIO - 1);
  localparam logic [CW-1:0] HALF_BEAT = CW'(RATIO / 2);

  // All state of the slice except the pin synchroniser lives in this one record.
  typedef struct packed {
    logic [CTRL_WIDTH-1:0] ctrl;
    tx_state_t             tx_st;
    logic [CW-1:0]         tx_cnt;
    logic [WORD-1:0]       tx_shift;
    logic [RATIO-1:0]      tx_err;
    logic [RATIO-1:0]      tx_side;
    logic [15:0]           lane_out;
    logic                  ecw_out;
    logic                  side_out;
    logic                  pins_oe;
    logic                  clk_out;
    logic                  clk_n;
    logic                  send_clk;
    logic [31:0]           tx_words;
    rx_state_t             rx_st;
    logic [CW-1:0]         rx_cnt;
    logic [WORD-1:0]       rx_acc;
    logic [RATIO-1:0]      rx_err_acc;
    logic [RATIO-1:0]      rx_side_acc;
    logic [WORD-1:0]       rx_word;
    logic [RATIO-1:0]      rx_err;
    logic [RATIO-1:0]      rx_side;
    logic                  recv_clk;
    logic                  rx_prev_clk;
    logic                  rx_fast_clk;
    logic [31:0]           rx_words;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } slice_st_t;

  slice_st_t   st_r;
  slice_st_t   st_nxt;
  logic [18:0] pin_s;
  logic        tx_on;
  logic        rx_on;
  logic        conflict;
  logic [15:0] rx_lane;
  logic        rx_ecw;
  logic        rx_side_bit;
  logic        rx_clk_src;
  logic        rx_edge;

  // Decodes a register offset; anything else gets an error answer.
  function automatic logic reg_hit(input logic [11:0] addr);
    return (addr == CTRL_OFFS) || (addr == STATUS_OFFS) || (addr == TX_WORDS_OFFS) ||
           (addr == RX_WORDS_OFFS) || (addr == CONFIG_OFFS);
  endfunction

  // Wraps a beat counter at the end of a word.
  function automatic logic [CW-1:0] next_beat(input logic [CW-1:0] cnt);
    return (cnt == LAST_BEAT) ? '0 : cnt + CW'(1);
  endfunction

  // Pin inputs cross into the clock domain before anyone looks at them.
  pin_sync #(
    .W (19)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .din     ({fwd_clk_in, side_wire_in, err_corr_wire_in, lane_wires_in}),
    .dout    (pin_s)
  );

  // R11 R13 path enables
  // Asking for both paths without loopback is refused: neither runs and status flags it.
  assign conflict = st_r.ctrl[CTRL_TX_EN_BIT] && st_r.ctrl[CTRL_RX_EN_BIT] &&
                    !st_r.ctrl[CTRL_LOOP_BIT];
  assign tx_on    = st_r.ctrl[CTRL_TX_EN_BIT] && !conflict;
  assign rx_on    = st_r.ctrl[CTRL_RX_EN_BIT] && !conflict;

  // R04 R12 receive source
  // Loopback takes the send flops directly, so no synchroniser delay is added there.
  always_comb begin
    if (st_r.ctrl[CTRL_LOOP_BIT]) begin
      rx_lane     = st_r.lane_out;
      rx_ecw      = st_r.ecw_out;
      rx_side_bit = st_r.side_out;
      rx_clk_src  = st_r.clk_out;
    end else begin
      rx_lane     = pin_s[15:0];
      rx_ecw      = HAS_EXTRA ? pin_s[16] : 1'b0;
      rx_side_bit = HAS_EXTRA ? pin_s[17] : 1'b0;
      rx_clk_src  = pin_s[18];
    end
  end

  // R15 double data rate
  // Every change of the forwarded clock, either direction, marks one beat.
  assign rx_edge = rx_clk_src != st_r.rx_prev_clk;

  // Next-state logic for the bus slave and both data paths.
  always_comb begin
    int ti;
    int ri;
    ti     = 0;
    ri     = 0;
    st_nxt = st_r;

    // Zero-wait slave: the answer is prepared in the setup cycle.
    st_nxt.pready  = 1'b1;
    if (psel && !penable) begin
      st_nxt.pslverr = !reg_hit(paddr);
      st_nxt.prdata  = 32'h0000_0000;
      case (paddr)
        CTRL_OFFS: begin
          st_nxt.prdata[CTRL_WIDTH-1:0] = st_r.ctrl;
        end
        STATUS_OFFS: begin
          st_nxt.prdata[STAT_TX_RUN_BIT]   = st_r.tx_st == TX_RUN;
          st_nxt.prdata[STAT_RX_RUN_BIT]   = st_r.rx_st == RX_RUN;
          st_nxt.prdata[STAT_RX_WAIT_BIT]  = st_r.rx_st == RX_WAIT_CLK;
          st_nxt.prdata[STAT_CONFLICT_BIT] = conflict;
          st_nxt.prdata[STAT_LOOP_BIT]     = st_r.ctrl[CTRL_LOOP_BIT];
        end
        TX_WORDS_OFFS: begin
          st_nxt.prdata = st_r.tx_words;
        end
        RX_WORDS_OFFS: begin
          st_nxt.prdata = st_r.rx_words;
        end
        CONFIG_OFFS: begin
          st_nxt.prdata[CFG_RATIO_POS +: 16] = 16'(RATIO);
          st_nxt.prdata[CFG_EXTRA_BIT]       = HAS_EXTRA;
        end
        default: begin
          st_nxt.prdata = 32'h0000_0000;
        end
      endcase
    end
    // Writes land only at the access edge; the counters are read only.
    if (psel && penable && st_r.pready && pwrite && paddr == CTRL_OFFS) begin
      st_nxt.ctrl = pwdata[CTRL_WIDTH-1:0];
    end

    // Transmit path.
    case (st_r.tx_st)
      TX_OFF: begin
        st_nxt.lane_out = 16'h0000;
        st_nxt.ecw_out  = 1'b0;
        st_nxt.side_out = 1'b0;
        st_nxt.pins_oe  = 1'b0;
        st_nxt.clk_out  = 1'b0;
        st_nxt.send_clk = 1'b0;
        st_nxt.tx_cnt   = '0;
        if (tx_on) begin
          st_nxt.tx_st = TX_RUN;
        end
      end
      TX_RUN: begin
        // R08 R16 clock division
        // The fast clock is sys_clk; a word takes RATIO beats, so the rates never change.
        st_nxt.pins_oe = 1'b1;
        st_nxt.clk_out = !st_r.clk_out;
        if (st_r.tx_cnt == '0) begin
          // R06 R09 word sampling
          // The send word is taken once per logic clock, at its rising edge.
          st_nxt.tx_shift = send_parallel_word;
          st_nxt.tx_err   = HAS_EXTRA ? send_err_corr_bits : '0;
          st_nxt.tx_side  = HAS_EXTRA ? send_side_bits : '0;
          st_nxt.tx_words = st_r.tx_words + 32'h0000_0001;
          // R17 lane mapping
          // Beat 0 carries bits 0..15 of the word, lane i on wire i.
          st_nxt.lane_out = send_parallel_word[LANES-1:0];
          st_nxt.ecw_out  = HAS_EXTRA ? send_err_corr_bits[0] : 1'b0;
          st_nxt.side_out = HAS_EXTRA ? send_side_bits[0] : 1'b0;
        end else begin
          ti              = int'(st_r.tx_cnt);
          st_nxt.lane_out = st_r.tx_shift[LANES*ti +: LANES];
          // R02 R04 extra bits
          // Error and side bits ride along like lane bits; contents are never examined.
          st_nxt.ecw_out  = st_r.tx_err[ti];
          st_nxt.side_out = st_r.tx_side[ti];
        end
        st_nxt.tx_cnt   = next_beat(st_r.tx_cnt);
        // R03 R16 logic clock
        // High for the first half of each word period, so its rate is fast clock over RATIO.
        st_nxt.send_clk = (st_nxt.tx_cnt != '0) && (st_nxt.tx_cnt <= HALF_BEAT);
        // Stopping only at a word boundary keeps the last word whole on the wires.
        if (!tx_on && st_r.tx_cnt == LAST_BEAT) begin
          st_nxt.tx_st = TX_OFF;
        end
      end
      default: begin
        st_nxt.tx_st = TX_OFF;
      end
    endcase
    // The complement leg is a flop of its own, so both legs leave on the same edge.
    st_nxt.clk_n = !st_nxt.clk_out;

    // Receive path.
    st_nxt.rx_prev_clk = rx_clk_src;
    st_nxt.rx_fast_clk = rx_on ? rx_clk_src : 1'b0;
    case (st_r.rx_st)
      RX_OFF: begin
        st_nxt.rx_cnt   = '0;
        st_nxt.recv_clk = 1'b0;
        if (rx_on) begin
          st_nxt.rx_st = RX_WAIT_CLK;
        end
      end
      RX_WAIT_CLK: begin
        // The first clock change after enabling is taken as beat 0 of a word.
        if (!rx_on) begin
          st_nxt.rx_st = RX_OFF;
        end else if (rx_edge) begin
          st_nxt.rx_acc[LANES-1:0] = rx_lane;
          st_nxt.rx_err_acc[0]     = rx_ecw;
          st_nxt.rx_side_acc[0]    = rx_side_bit;
          st_nxt.rx_cnt            = next_beat('0);
          st_nxt.rx_st             = RX_RUN;
        end
      end
      RX_RUN: begin
        if (!rx_on) begin
          st_nxt.rx_st = RX_OFF;
        end else if (rx_edge) begin
          // R17 lane mapping
          // Beat k fills bits 16k..16k+15, undoing the sender's order.
          ri                               = int'(st_r.rx_cnt);
          st_nxt.rx_acc[LANES*ri +: LANES] = rx_lane;
          st_nxt.rx_err_acc[ri]            = rx_ecw;
          st_nxt.rx_side_acc[ri]           = rx_side_bit;
          st_nxt.rx_cnt                    = next_beat(st_r.rx_cnt);
          if (st_r.rx_cnt == LAST_BEAT) begin
            // R10 R18 word output
            // A finished word is shown whole and the logic clock rises with it.
            st_nxt.rx_word  = st_nxt.rx_acc;
            st_nxt.rx_err   = st_nxt.rx_err_acc;
            st_nxt.rx_side  = st_nxt.rx_side_acc;
            st_nxt.recv_clk = 1'b1;
            st_nxt.rx_words = st_r.rx_words + 32'h0000_0001;
          end else if (st_nxt.rx_cnt == HALF_BEAT) begin
            // R18 derived clock
            // The fall is paced by forwarded edges, so it follows the sender's rate.
            st_nxt.recv_clk = 1'b0;
          end
        end
      end
      default: begin
        st_nxt.rx_st = RX_OFF;
      end
    endcase
  end

  // One register stage holds the whole slice record; reset leaves both paths off.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r          <= '0;
      st_r.ctrl     <= CTRL_RESET;
      st_r.clk_n    <= 1'b1;
      st_r.tx_st    <= TX_OFF;
      st_r.rx_st    <= RX_OFF;
      st_r.tx_words <= COUNT_RESET;
      st_r.rx_words <= COUNT_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // R01 R12 pin drive
  // One wire set is shared; enables follow the send path and extras stay idle if absent.
  assign lane_wires_out     = st_r.lane_out;
  assign lane_wires_oe      = {16{st_r.pins_oe}};
  assign err_corr_wire_out  = st_r.ecw_out;
  assign err_corr_wire_oe   = st_r.pins_oe && HAS_EXTRA;
  assign side_wire_out      = st_r.side_out;
  assign side_wire_oe       = st_r.pins_oe && HAS_EXTRA;
  assign fwd_clk_p_out      = st_r.clk_out;
  assign fwd_clk_n_out      = st_r.clk_n;
  assign fwd_clk_oe         = st_r.pins_oe;

  // Link layer side outputs.
  assign send_logic_clock   = st_r.send_clk;
  assign recv_parallel_word = st_r.rx_word;
  assign recv_err_corr_bits = st_r.rx_err;
  assign recv_side_bits     = st_r.rx_side;
  assign recv_logic_clock   = st_r.recv_clk;
  assign recv_fast_clk_out  = st_r.rx_fast_clk;

  // Bus answer outputs.
  assign prdata             = st_r.prdata;
  assign pready             = st_r.pready;
  assign pslverr            = st_r.pslverr;

endmodule

// File: sim/peer_slice_model.sv
`timescale 1ns/1ps
// Far-side sending slice; it frames the held word onto the wires, starting a new frame only while go is high.
module peer_slice_model #(
  parameter int RATIO = 4
) (
  input  wire logic                sys_clk,
  input  wire logic                go,
  input  wire logic [16*RATIO-1:0] word,
  input  wire logic [RATIO-1:0]    ecc,
  input  wire logic [RATIO-1:0]    side,
  output logic      [15:0]         lanes,
  output logic                     ecc_wire,
  output logic                     side_wire,
  output logic                     fwd_clk
);
  int cnt = 0;

  // Start from a quiet line.
  initial begin
    lanes = 16'h0000;
    {ecc_wire, side_wire, fwd_clk} = 3'h0;
  end

  // Between frames the clock stands still and the data wires flip every cycle,
  // so a receiver that samples outside a frame sees garbage, not stale data.
  always @(posedge sys_clk) begin
    if (cnt == 0 && !go) begin
      lanes     <= ~lanes;
      ecc_wire  <= ~ecc_wire;
      side_wire <= ~side_wire;
    end else begin
      lanes     <= word[16*cnt +: 16];
      ecc_wire  <= ecc[cnt];
      side_wire <= side[cnt];
      fwd_clk   <= ~fwd_clk;
      cnt       <= (cnt + 1) % RATIO;
    end
  end
endmodule

// File: sim/d2d_slice_assertions.sv
`timescale 1ns/1ps
module d2d_slice_assertions
  import d2d_slice_pkg::*;
#(
  parameter int RATIO     = 4,
  parameter bit HAS_EXTRA = 1'b1
) (
  input wire logic                sys_clk,
  input wire logic                nrst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic                pready,
  input wire logic [11:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                send_logic_clock,
  input wire logic [16*RATIO-1:0] recv_parallel_word,
  input wire logic [RATIO-1:0]    recv_side_bits,
  input wire logic                recv_logic_clock,
  input wire logic [15:0]         lane_wires_oe,
  input wire logic                err_corr_wire_oe,
  input wire logic                side_wire_oe,
  input wire logic                fwd_clk_p_out,
  input wire logic                fwd_clk_n_out,
  input wire logic                fwd_clk_oe
);
  logic [2:0] ctrl_r;
  logic [2:0] ctrl_nxt;

  // Mode shadow, taken at the access edge just as the slave takes it.
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (psel && penable && pready && pwrite && paddr == CTRL_OFFS) begin
      ctrl_nxt = pwdata[2:0];
    end
  end

  // Mode shadow register.
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  // A logic clock period begins.
  sequence s_launch;
    $rose(send_logic_clock);
  endsequence

  // The next period begins unless sending was switched off.
  sequence s_relaunch;
    $rose(send_logic_clock) || !fwd_clk_oe;
  endsequence

  a_fwd_clk_diff:
    assert property (fwd_clk_n_out == !fwd_clk_p_out) else $error("clock pair skewed");
  a_fwd_clk_ddr:
    assert property (fwd_clk_oe && $past(fwd_clk_oe) |-> fwd_clk_p_out != $past(fwd_clk_p_out))
    else $error("forwarded clock missed a beat");
  a_lane_oe_whole:
    assert property (lane_wires_oe == 16'h0000 || lane_wires_oe == 16'hffff)
    else $error("lane enables split");
  a_extra_pair:
    assert property (err_corr_wire_oe == side_wire_oe) else $error("extra wires differ");
  a_extra_with_lanes:
    assert property (err_corr_wire_oe == (lane_wires_oe[0] && HAS_EXTRA))
    else $error("extra wire out of step");
  a_send_clk_period:
    assert property (s_launch |-> ##RATIO s_relaunch) else $error("logic clock period wrong");
  a_rx_word_aligned:
    assert property (!$stable(recv_parallel_word) |-> $rose(recv_logic_clock))
    else $error("word changed off the logic clock");
  a_rx_extra_aligned:
    assert property (!$stable(recv_side_bits) |-> $rose(recv_logic_clock))
    else $error("side bits changed off the logic clock");
  a_conflict_quiet:
    assert property ((ctrl_r == 3'h3)[*8] |-> lane_wires_oe == 16'h0000 && !fwd_clk_oe)
    else $error("both paths ran without loopback");
  a_rx_only_quiet:
    assert property ((ctrl_r == 3'h2)[*8] |-> lane_wires_oe == 16'h0000 && !fwd_clk_oe)
    else $error("receiver drove the wires");
endmodule

bind d2d_phy_slice_gearbox d2d_slice_assertions #(.RATIO(RATIO), .HAS_EXTRA(HAS_EXTRA))
  d2d_slice_assertions_i (
  .sys_clk, .nrst, .psel, .penable, .pwrite, .pready, .paddr, .pwdata, .send_logic_clock,
  .recv_parallel_word, .recv_side_bits, .recv_logic_clock, .lane_wires_oe,
  .err_corr_wire_oe, .side_wire_oe, .fwd_clk_p_out, .fwd_clk_n_out, .fwd_clk_oe
);

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import d2d_slice_pkg::*;

  localparam int N = 4;

  logic            sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata;
  logic [16*N-1:0] send_parallel_word, recv_parallel_word, peer_word;
  logic [N-1:0]    send_err_corr_bits, send_side_bits, peer_ecc, peer_side;
  logic [N-1:0]    recv_err_corr_bits, recv_side_bits;
  logic [15:0]     lane_wires_in, lane_wires_out, lane_wires_oe, peer_lanes;
  logic            err_corr_wire_in, err_corr_wire_out, err_corr_wire_oe, peer_ecc_w;
  logic            side_wire_in, side_wire_out, side_wire_oe, peer_side_w;
  logic            fwd_clk_in, fwd_clk_p_out, fwd_clk_n_out, fwd_clk_oe, peer_clk;
  logic            send_logic_clock, recv_logic_clock, recv_fast_clk_out, peer_go;
  integer          seed = 32'hb062;
  int              error_cnt = 0;
  int              check_count = 0;

  // Shared wires: an enabled slice driver wins, the peer drives otherwise.
  assign lane_wires_in    = (lane_wires_oe & lane_wires_out) | (~lane_wires_oe & peer_lanes);
  assign err_corr_wire_in = err_corr_wire_oe ? err_corr_wire_out : peer_ecc_w;
  assign side_wire_in     = side_wire_oe ? side_wire_out : peer_side_w;
  assign fwd_clk_in       = fwd_clk_oe ? fwd_clk_p_out : peer_clk;

  d2d_phy_slice_gearbox #(.RATIO(N), .HAS_EXTRA(1'b1)) d2d_phy_slice_gearbox_i (
    .sys_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .send_parallel_word, .send_err_corr_bits, .send_side_bits, .send_logic_clock,
    .recv_parallel_word, .recv_err_corr_bits, .recv_side_bits, .recv_logic_clock,
    .recv_fast_clk_out, .lane_wires_in, .lane_wires_out, .lane_wires_oe, .err_corr_wire_in,
    .err_corr_wire_out, .err_corr_wire_oe, .side_wire_in, .side_wire_out, .side_wire_oe,
    .fwd_clk_in, .fwd_clk_p_out, .fwd_clk_n_out, .fwd_clk_oe
  );

  peer_slice_model #(.RATIO(N)) peer_slice_model_i (
    .sys_clk, .go(peer_go), .word(peer_word), .ecc(peer_ecc), .side(peer_side),
    .lanes(peer_lanes), .ecc_wire(peer_ecc_w), .side_wire(peer_side_w), .fwd_clk(peer_clk)
  );

  // clock source
  // 100 MHz clock; the link layer side of the bench never makes it.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Lane i of beat k carries word bit 16k+i.
  function automatic logic [15:0] beat(input logic [16*N-1:0] w, input int k);
    return w[16*k +: 16];
  endfunction

  // Counted comparison.
  task automatic chk(input logic [79:0] got, input logic [79:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask

  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic slverr);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chk(n < 50, 1'b1);
    rdv     = prdata;
    slverr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits for the next received word, sampled away from the clock edge.
  task automatic wait_word();
    int n;
    n = 0;
    @(negedge sys_clk);
    while (recv_logic_clock !== 1'b0 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    while (recv_logic_clock !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 100, 1'b1);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end

  initial begin
    int              n;
    logic [31:0]     rd;
    logic            err;
    logic [16*N-1:0] cur;
    logic [N-1:0]    cure, curs;
    nrst = 1'b0;
    {psel, penable, pwrite, peer_go} = 4'h0;
    {paddr, pwdata} = 44'h0;
    {send_parallel_word, send_err_corr_bits, send_side_bits} = 72'h0;
    {peer_word, peer_ecc, peer_side} = 72'h0;
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    apb(1'b0, CONFIG_OFFS, 32'h0, rd, err);
    chk(rd, {15'h0, 1'b1, 16'(N)});
    apb(1'b1, CONFIG_OFFS, 32'hffff_ffff, rd, err);
    apb(1'b0, CONFIG_OFFS, 32'h0, rd, err);
    chk(rd, {15'h0, 1'b1, 16'(N)});
    apb(1'b0, 12'h7fc, 32'h0, rd, err);
    chk({err, rd}, {1'b1, 32'h0});
    $display("test registers done");
    send_parallel_word <= {$random(seed), $random(seed)};
    send_err_corr_bits <= N'($random(seed));
    send_side_bits     <= N'($random(seed));
    apb(1'b1, CTRL_OFFS, 32'h1, rd, err);
    n = 0;
    while (lane_wires_oe !== 16'hffff && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n < 50, 1'b1);
    repeat (3) begin
      cur  = send_parallel_word;
      cure = send_err_corr_bits;
      curs = send_side_bits;
      for (int k = 0; k < N; k++) begin
        chk(lane_wires_out, beat(cur, k));
        chk({err_corr_wire_out, side_wire_out}, {cure[k], curs[k]});
        chk(send_logic_clock, k < N / 2);
        chk(fwd_clk_p_out, k % 2 == 0);
        @(posedge sys_clk);
        if (k == 0) begin
          send_parallel_word <= {$random(seed), $random(seed)};
          send_err_corr_bits <= N'($random(seed));
          send_side_bits     <= N'($random(seed));
        end
        @(negedge sys_clk);
      end
    end
    apb(1'b1, CTRL_OFFS, 32'h0, rd, err);
    repeat (10) @(posedge sys_clk);
    chk({lane_wires_oe, fwd_clk_oe}, 17'h0);
    $display("test send done");
    apb(1'b1, CTRL_OFFS, 32'h7, rd, err);
    wait_word();
    wait_word();
    chk(recv_parallel_word, send_parallel_word);
    chk({recv_err_corr_bits, recv_side_bits}, {send_err_corr_bits, send_side_bits});
    apb(1'b1, CTRL_OFFS, 32'h0, rd, err);
    $display("test loopback done");
    apb(1'b1, CTRL_OFFS, 32'h3, rd, err);
    repeat (10) @(posedge sys_clk);
    apb(1'b0, STATUS_OFFS, 32'h0, rd, err);
    chk(rd[STAT_CONFLICT_BIT], 1'b1);
    chk(lane_wires_oe, 16'h0);
    apb(1'b1, CTRL_OFFS, 32'h0, rd, err);
    $display("test conflict done");
    peer_word <= {$random(seed), $random(seed)};
    peer_ecc  <= N'($random(seed));
    // inversion flags
    // The far link layer may put inversion flags here; the slice must carry them blindly.
    peer_side <= N'($random(seed));
    apb(1'b1, CTRL_OFFS, 32'h2, rd, err);
    apb(1'b0, CTRL_OFFS, 32'h0, rd, err);
    chk(rd, 32'h2);
    peer_go <= 1'b1;
    wait_word();
    wait_word();
    chk(recv_parallel_word, peer_word);
    chk({recv_err_corr_bits, recv_side_bits}, {peer_ecc, peer_side});
    chk({lane_wires_oe, fwd_clk_oe}, 17'h0);
    chk(recv_fast_clk_out, 1'b0);
    @(negedge sys_clk);
    chk(recv_fast_clk_out, 1'b1);
    apb(1'b0, STATUS_OFFS, 32'h0, rd, err);
    chk(rd, 32'h1 << STAT_RX_RUN_BIT);
    @(posedge sys_clk);
    peer_go <= 1'b0;
    $display("test receive done");
    summarize();
  end
endmodule
